// File: verilog/host_io_params.svh
// constants for the host image access block: codes, bases, sizes
`ifndef HOST_IO_PARAMS_SVH
`define HOST_IO_PARAMS_SVH

// ----------------------------------------------------------------
// assembly messaging
// ----------------------------------------------------------------
`define SVC_READ_ASM 8'h0E
`define SVC_WRITE_ASM 8'h10
`define ASM_CLASS 8'h04
`define ASM_ATTR 8'h03
`define INST_RESPONSE 8'h64
`define INST_COMMAND 8'h96
`define IMAGE_BYTES 16'h0014
`define IMAGE_WORDS 16'h000A
`define IMAGE_BITS 16'h00A0
`define CIP_BAD_SERVICE 8'h08
`define CIP_SHORT 8'h13
`define CIP_BAD_ATTR 8'h14
`define CIP_LONG 8'h15
`define CIP_NO_OBJECT 8'h16

// ----------------------------------------------------------------
// register table map
// ----------------------------------------------------------------
`define RESP_REG_BASE 16'h0000
`define CMD_REG_BASE 16'h0400
`define CMD_COIL_BASE 16'h4000
`define COIL_ON 16'hFF00
`define COIL_OFF 16'h0000
`define FC_RD_COILS 8'h01
`define FC_RD_INPUTS 8'h02
`define FC_RD_HOLDING 8'h03
`define FC_RD_INREGS 8'h04
`define FC_WR_COIL 8'h05
`define FC_WR_REG 8'h06
`define FC_WR_COILS 8'h0F
`define FC_WR_REGS 8'h10
`define FC_MASK_REG 8'h16
`define EXC_FUNCTION 8'h01
`define EXC_ADDRESS 8'h02
`define EXC_VALUE 8'h03

`endif

// File: verilog/host_io_pkg.sv
// types shared by the host image access block
package host_io_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10,
        ST_DONE = 2'b11
    } state_e;

    // classified request kinds
    typedef enum logic [2:0] {
        OP_REFUSE = 3'b000,
        OP_RD_WORDS = 3'b001,
        OP_RD_BITS = 3'b010,
        OP_WR_WORDS = 3'b011,
        OP_WR_BITS = 3'b100,
        OP_WR_COIL = 3'b101,
        OP_MASK = 3'b110
    } op_e;

endpackage

// File: verilog/cmd_image_bank.sv
// command image: staged copy filled by one transfer, live copy swapped on commit
module cmd_image_bank (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // staging control
    input wire logic load,
    input wire logic word_en,
    input wire logic bit_en,
    input wire logic [7:0] idx,
    input wire logic [15:0] word_in,
    input wire logic bit_in,
    input wire logic commit,
    // images
    output logic [159:0] live,
    output logic [15:0] stage_word
);

    logic [159:0] live_q;
    logic [159:0] stage_q;

    // word n at bits 16n..16n+15, so bit index equals coil offset
    assign live = live_q;
    assign stage_word = stage_q[{idx[3:0], 4'h0} +: 16];

    // staged writes never reach the driver until the whole transfer commits
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            live_q <= 160'h0;
            stage_q <= 160'h0;
        end else begin
            if (load) begin
                stage_q <= live_q;
            end else if (word_en) begin
                stage_q[{idx[3:0], 4'h0} +: 16] <= word_in;
            end else if (bit_en) begin
                stage_q[idx] <= bit_in;
            end
            if (commit) begin
                live_q <= stage_q;
            end
        end
    end

endmodule

// File: verilog/req_decode.sv
// classifies one request header into an operation, a range or a refusal
`include "host_io_params.svh"
module req_decode (
    // request header
    input wire logic is_cip,
    input wire logic [7:0] code,
    input wire logic [7:0] cls,
    input wire logic [7:0] inst,
    input wire logic [7:0] attr,
    input wire logic [15:0] addr,
    input wire logic [15:0] qty,
    // classification
    output host_io_pkg::op_e op,
    output logic src_cmd,
    output logic [7:0] first,
    output logic [7:0] count,
    output logic [7:0] exc
);

    // zero based range test from a base; 17 bits so the end cannot wrap
    function automatic logic fits(input logic [15:0] a, input logic [15:0] n,
                                  input logic [15:0] base, input logic [15:0] size);
        logic [16:0] end_a;
        end_a = {1'b0, a} + {1'b0, n};
        fits = (a >= base) && (end_a <= ({1'b0, base} + {1'b0, size}));
    endfunction

    // ----------------------------------------------------------------
    // range decode
    // ----------------------------------------------------------------
    wire logic single = (code == `FC_WR_COIL) || (code == `FC_WR_REG) ||
                        (code == `FC_MASK_REG);
    wire logic [15:0] n = single ? 16'h0001 : qty;
    wire logic in_resp_w = fits(addr, n, `RESP_REG_BASE, `IMAGE_WORDS);
    wire logic in_cmd_w = fits(addr, n, `CMD_REG_BASE, `IMAGE_WORDS);
    wire logic in_resp_b = fits(addr, n, `RESP_REG_BASE, `IMAGE_BITS);
    wire logic in_cmd_b = fits(addr, n, `CMD_COIL_BASE, `IMAGE_BITS);
    wire logic [15:0] off_cmd_w = addr - `CMD_REG_BASE;
    wire logic [15:0] off_cmd_b = addr - `CMD_COIL_BASE;
    wire logic rd_svc = (code == `SVC_READ_ASM);
    wire logic [7:0] want_inst = rd_svc ? `INST_RESPONSE : `INST_COMMAND;

    host_io_pkg::op_e tgt;
    logic ok;
    logic tsrc;
    logic [7:0] toff;

    // ----------------------------------------------------------------
    // function select
    // ----------------------------------------------------------------
    always_comb begin
        tgt = host_io_pkg::OP_REFUSE;
        ok = 1'b0;
        tsrc = 1'b0;
        toff = addr[7:0];
        case (code)
            `FC_RD_COILS: begin
                tgt = host_io_pkg::OP_RD_BITS;
                ok = in_cmd_b;
                tsrc = 1'b1;
                toff = off_cmd_b[7:0];
            end
            `FC_RD_INPUTS: begin
                tgt = host_io_pkg::OP_RD_BITS;
                ok = in_resp_b;
            end
            `FC_RD_HOLDING: begin
                tgt = host_io_pkg::OP_RD_WORDS;
                ok = in_resp_w || in_cmd_w;
                tsrc = !in_resp_w;
                toff = in_resp_w ? addr[7:0] : off_cmd_w[7:0];
            end
            `FC_RD_INREGS: begin
                tgt = host_io_pkg::OP_RD_WORDS;
                ok = in_resp_w;
            end
            `FC_WR_COIL, `FC_WR_COILS: begin
                tgt = (code == `FC_WR_COIL) ? host_io_pkg::OP_WR_COIL : host_io_pkg::OP_WR_BITS;
                ok = in_cmd_b;
                tsrc = 1'b1;
                toff = off_cmd_b[7:0];
            end
            `FC_WR_REG, `FC_WR_REGS, `FC_MASK_REG: begin
                tgt = (code == `FC_MASK_REG) ? host_io_pkg::OP_MASK : host_io_pkg::OP_WR_WORDS;
                ok = in_cmd_w;
                tsrc = 1'b1;
                toff = off_cmd_w[7:0];
            end
            default: begin
                tgt = host_io_pkg::OP_REFUSE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // verdict
    // ----------------------------------------------------------------
    always_comb begin
        op = host_io_pkg::OP_REFUSE;
        src_cmd = 1'b0;
        first = 8'h00;
        count = 8'h00;
        exc = 8'h00;
        if (is_cip) begin
            if (!rd_svc && code != `SVC_WRITE_ASM) begin
                exc = `CIP_BAD_SERVICE;
            end else if (cls != `ASM_CLASS || inst != want_inst) begin
                exc = `CIP_NO_OBJECT;
            end else if (attr != `ASM_ATTR) begin
                exc = `CIP_BAD_ATTR;
            end else if (rd_svc) begin
                op = host_io_pkg::OP_RD_WORDS;
                count = 8'h0A;
            end else if (qty < `IMAGE_BYTES) begin
                exc = `CIP_SHORT;
            end else if (qty > `IMAGE_BYTES) begin
                exc = `CIP_LONG;
            end else begin
                op = host_io_pkg::OP_WR_WORDS;
                src_cmd = 1'b1;
                count = 8'h0A;
            end
        end else if (tgt == host_io_pkg::OP_REFUSE) begin
            exc = `EXC_FUNCTION;
        end else if (n == 16'h0000) begin
            exc = `EXC_VALUE;
        end else if (!ok) begin
            exc = `EXC_ADDRESS;
        end else begin
            op = tgt;
            src_cmd = tsrc;
            first = toff;
            count = (tgt == host_io_pkg::OP_MASK) ? 8'h02 : n[7:0];
        end
    end

endmodule

// File: verilog/host_io_image_access.sv
// host access to the 20 byte command and response images
`include "host_io_params.svh"
// Behaviour
// - read assembly service E returns response image
// - write assembly service 10 accepts command image
// - only class 4 attribute 3 served
// - response image at instance 100
// - command image at instance 150
// - assembly transfers carry exactly 20 bytes
// - table addresses are zero based references
// - discrete inputs and input registers share memory
// - response data starts at address 0
// - input n is bit n mod 16
// - coils and holding registers share command memory
// - holding registers at 1024, coils at 16384
// - coil 16384 is bit 0, ascending bits
// - inputs carry responses, outputs carry commands
// - unknown function answers exception 01
// - address outside image answers exception 02
module host_io_image_access (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // request header
    input wire logic hdr_valid,
    input wire logic hdr_is_cip,
    input wire logic [7:0] hdr_code,
    input wire logic [7:0] hdr_class,
    input wire logic [7:0] hdr_instance,
    input wire logic [7:0] hdr_attribute,
    input wire logic [15:0] hdr_addr,
    input wire logic [15:0] hdr_qty,
    output logic hdr_ready,
    // write data beats
    input wire logic wr_valid,
    input wire logic [15:0] wr_data,
    output logic wr_ready,
    // answer
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic rsp_done,
    output logic rsp_error,
    output logic [7:0] rsp_code,
    // driver side images
    input wire logic [159:0] resp_image,
    output logic [159:0] cmd_image,
    output logic cmd_update
);

    function automatic logic is_write(input host_io_pkg::op_e op);
        is_write = (op == host_io_pkg::OP_WR_WORDS) || (op == host_io_pkg::OP_WR_BITS) ||
                   (op == host_io_pkg::OP_WR_COIL) || (op == host_io_pkg::OP_MASK);
    endfunction

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    host_io_pkg::op_e dec_op;
    logic dec_src;
    logic [7:0] dec_first;
    logic [7:0] dec_count;
    logic [7:0] dec_exc;

    req_decode u_decode (
        .is_cip(hdr_is_cip),
        .code(hdr_code),
        .cls(hdr_class),
        .inst(hdr_instance),
        .attr(hdr_attribute),
        .addr(hdr_addr),
        .qty(hdr_qty),
        .op(dec_op),
        .src_cmd(dec_src),
        .first(dec_first),
        .count(dec_count),
        .exc(dec_exc)
    );

    host_io_pkg::state_e state_q;
    host_io_pkg::state_e state_d;
    host_io_pkg::op_e op_q;
    logic src_q;
    logic [7:0] idx_q;
    logic [7:0] cnt_q;
    logic err_q;
    logic [7:0] code_q;
    logic [15:0] and_q;
    logic [159:0] snap_q;
    logic [15:0] stage_word;

    // handshake and sequencing terms
    wire logic accept = hdr_valid && hdr_ready;
    wire logic take = wr_valid && wr_ready;
    wire logic last_beat = (cnt_q == 8'h01);
    wire logic refuse = (dec_op == host_io_pkg::OP_REFUSE);
    wire logic in_read = (state_q == host_io_pkg::ST_READ);
    wire logic in_done = (state_q == host_io_pkg::ST_DONE);

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // one flat image: input n and register bit share an index
    wire logic [159:0] rd_img = src_q ? cmd_image : snap_q;
    wire logic [15:0] rd_word = rd_img[{idx_q[3:0], 4'h0} +: 16];
    wire logic [15:0] rd_item = (op_q == host_io_pkg::OP_RD_BITS) ?
                                {15'h0000, rd_img[idx_q]} : rd_word;

    // ----------------------------------------------------------------
    // write path
    // ----------------------------------------------------------------
    wire logic coil_ok = (wr_data == `COIL_ON) || (wr_data == `COIL_OFF);
    wire logic [15:0] masked = (stage_word & and_q) | (wr_data & ~and_q);
    wire logic is_mask = (op_q == host_io_pkg::OP_MASK);
    wire logic is_coil = (op_q == host_io_pkg::OP_WR_COIL);
    wire logic word_en = take && ((op_q == host_io_pkg::OP_WR_WORDS) || (is_mask && last_beat));
    wire logic bit_en = take && ((op_q == host_io_pkg::OP_WR_BITS) || (is_coil && coil_ok));
    wire logic bit_in = is_coil ? (wr_data == `COIL_ON) : wr_data[0];
    wire logic [15:0] word_in = is_mask ? masked : wr_data;
    wire logic load = accept && is_write(dec_op);
    // swap only after a clean, complete transfer
    wire logic commit = in_done && is_write(op_q) && !err_q;

    // command memory shared by coils and holding registers
    cmd_image_bank u_bank (
        .clock(clock),
        .reset_n(reset_n),
        .load(load),
        .word_en(word_en),
        .bit_en(bit_en),
        .idx(idx_q),
        .word_in(word_in),
        .bit_in(bit_in),
        .commit(commit),
        .live(cmd_image),
        .stage_word(stage_word)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            host_io_pkg::ST_IDLE: begin
                if (accept) begin
                    state_d = refuse ? host_io_pkg::ST_DONE :
                              is_write(dec_op) ? host_io_pkg::ST_WRITE : host_io_pkg::ST_READ;
                end
            end
            host_io_pkg::ST_READ: begin
                if (last_beat) state_d = host_io_pkg::ST_DONE;
            end
            host_io_pkg::ST_WRITE: begin
                if (take && last_beat) state_d = host_io_pkg::ST_DONE;
            end
            host_io_pkg::ST_DONE: begin
                state_d = host_io_pkg::ST_IDLE;
            end
            default: begin
                state_d = host_io_pkg::ST_IDLE;
            end
        endcase
    end

    // transfer bookkeeping; a mask write keeps its index for both beats
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q <= host_io_pkg::ST_IDLE;
            op_q <= host_io_pkg::OP_REFUSE;
            src_q <= 1'b0;
            idx_q <= 8'h00;
            cnt_q <= 8'h00;
        end else begin
            state_q <= state_d;
            if (accept) begin
                op_q <= dec_op;
                src_q <= dec_src;
                idx_q <= dec_first;
                cnt_q <= dec_count;
            end else if (in_read || take) begin
                cnt_q <= cnt_q - 8'h01;
                if (!is_mask) idx_q <= idx_q + 8'h01;
            end
        end
    end

    // exception code held for the done beat; bad coil value is 03
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            err_q <= 1'b0;
            code_q <= 8'h00;
            and_q <= 16'h0000;
        end else if (accept) begin
            err_q <= refuse;
            code_q <= dec_exc;
        end else if (take && is_coil && !coil_ok) begin
            err_q <= 1'b1;
            code_q <= `EXC_VALUE;
        end else if (take && is_mask && !last_beat) begin
            and_q <= wr_data;
        end
    end

    // snapshot so one read returns a coherent response image
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            snap_q <= 160'h0;
        end else if (accept) begin
            snap_q <= resp_image;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            hdr_ready <= 1'b0;
            wr_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 16'h0000;
            rsp_done <= 1'b0;
            rsp_error <= 1'b0;
            rsp_code <= 8'h00;
            cmd_update <= 1'b0;
        end else begin
            hdr_ready <= (state_d == host_io_pkg::ST_IDLE);
            wr_ready <= (state_d == host_io_pkg::ST_WRITE);
            rsp_valid <= in_read;
            rsp_data <= in_read ? rd_item : 16'h0000;
            rsp_done <= in_done;
            rsp_error <= in_done && err_q;
            if (in_done) rsp_code <= err_q ? code_q : 8'h00;
            cmd_update <= commit;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    wire logic cip_ok = hdr_class == `ASM_CLASS && hdr_attribute == `ASM_ATTR;
    wire logic cip_rd = accept && hdr_is_cip && hdr_code == `SVC_READ_ASM;
    wire logic cip_wr = accept && hdr_is_cip && hdr_code == `SVC_WRITE_ASM;
    wire logic mb = accept && !hdr_is_cip;

    AST_CIP_READ_IMAGE: assert property (
        cip_rd && cip_ok && hdr_instance == `INST_RESPONSE
        |-> ##2 rsp_valid [*8] ##1 rsp_valid [*2] ##1 (rsp_done && !rsp_error))
        else $error("assembly read did not return ten words");
    AST_CIP_WRITE_TAKEN: assert property (
        cip_wr && cip_ok && hdr_instance == `INST_COMMAND && hdr_qty == `IMAGE_BYTES
        |=> wr_ready)
        else $error("assembly write not accepted");
    AST_CIP_BAD_CLASS: assert property (
        (cip_rd || cip_wr) && hdr_class != `ASM_CLASS
        |-> ##2 rsp_done && rsp_error && rsp_code == `CIP_NO_OBJECT)
        else $error("wrong class not refused");
    AST_CIP_READ_INST: assert property (
        cip_rd && hdr_instance != `INST_RESPONSE |-> ##2 rsp_error && !rsp_valid)
        else $error("read served at wrong instance");
    AST_CIP_WRITE_INST: assert property (
        cip_wr && hdr_instance != `INST_COMMAND |-> ##2 rsp_error && !cmd_update)
        else $error("write served at wrong instance");
    AST_CIP_LENGTH: assert property (
        cip_wr && cip_ok && hdr_instance == `INST_COMMAND && hdr_qty != `IMAGE_BYTES
        |-> ##2 rsp_error && !$past(wr_ready))
        else $error("write of wrong length accepted");
    AST_RESP_ZERO: assert property (
        mb && hdr_code == `FC_RD_INPUTS && hdr_addr == 16'h0000
        |-> ##2 rsp_valid && rsp_data == {15'h0000, $past(resp_image[0], 2)})
        else $error("discrete input 0 is not response bit 0");
    AST_INPUT_BIT48: assert property (
        mb && hdr_code == `FC_RD_INPUTS && hdr_addr == 16'h0030
        |-> ##2 rsp_valid && rsp_data[0] == $past(resp_image[48], 2))
        else $error("discrete input 48 is not bit 0 of register 3");
    AST_COIL_BIT0: assert property (
        mb && hdr_code == `FC_RD_COILS && hdr_addr == `CMD_COIL_BASE
        |-> ##2 rsp_valid && rsp_data[0] == $past(cmd_image[0], 2))
        else $error("coil 16384 is not bit 0 of holding register 1024");
    AST_HOLD_BASE: assert property (
        mb && hdr_code == `FC_WR_REG && hdr_addr == `CMD_REG_BASE |=> wr_ready)
        else $error("holding register 1024 not writable");
    AST_BAD_FUNCTION: assert property (
        mb && hdr_code == 8'h17 |-> ##2 rsp_done && rsp_code == `EXC_FUNCTION)
        else $error("unknown function not answered with 01");
    AST_BAD_ADDRESS: assert property (
        mb && hdr_code == `FC_RD_INREGS && hdr_addr == 16'h0009 && hdr_qty == 16'h0002
        |-> ##2 rsp_done && rsp_code == `EXC_ADDRESS)
        else $error("out of range address not answered with 02");
    AST_ATOMIC_UPDATE: assert property (
        !$stable(cmd_image) |-> cmd_update && $past(in_done))
        else $error("command image changed outside a commit");

    COV_CIP_READ: cover property (cip_rd ##2 rsp_valid [*8] ##1 rsp_valid [*2] ##1 rsp_done);
    COV_COMMIT: cover property (cmd_update);
    COV_EXCEPTION: cover property (rsp_done && rsp_error);

endmodule

// File: test/host_model.sv
// host controller model issuing assembly and table requests
`include "host_io_params.svh"
module host_model (
    // clock and block handshakes
    input wire logic clock,
    input wire logic hdr_ready,
    input wire logic wr_ready,
    // request header
    output logic hdr_valid,
    output logic hdr_is_cip,
    output logic [7:0] hdr_code,
    output logic [7:0] hdr_class,
    output logic [7:0] hdr_instance,
    output logic [7:0] hdr_attribute,
    output logic [15:0] hdr_addr,
    output logic [15:0] hdr_qty,
    // write beats
    output logic wr_valid,
    output logic [15:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [64:0] h;
    // header fields travel as one vector so a release can invert them all
    assign {hdr_is_cip, hdr_code, hdr_class, hdr_instance, hdr_attribute, hdr_addr, hdr_qty} = h;
    initial begin
        hdr_valid = 1'b0;
        wr_valid = 1'b0;
        h = '0;
        wr_data = 16'h0000;
    end
    task automatic send(input logic [64:0] r, output bit ok);
        ok = 1'b0;
        @(posedge clock);
        hdr_valid <= 1'b1;
        h <= r;
        for (int n = 0; n < 50 && !ok; n++) begin
            @(posedge clock);
            ok = (hdr_ready === 1'b1);
        end
        hdr_valid <= 1'b0;
        h <= ~r; // stale fields never look valid
    endtask
    // beats held until each is taken
    task automatic beats(input logic [159:0] img, input int cnt, output bit ok);
        int i = 0;
        wr_valid <= 1'b1;
        wr_data <= img[15:0];
        for (int n = 0; n < 80 && i < cnt; n++) begin
            @(posedge clock);
            if (wr_ready === 1'b1) begin
                i++;
                if (i < cnt) wr_data <= img[16*i +: 16];
            end
        end
        wr_valid <= 1'b0;
        wr_data <= ~wr_data;
        ok = (i == cnt);
    endtask
    task automatic asm_read(output bit ok);
        send({1'b1, `SVC_READ_ASM, `ASM_CLASS, `INST_RESPONSE, `ASM_ATTR, 16'h0000,
            `IMAGE_BYTES}, ok);
    endtask
    // write assembly and its ten words
    task automatic asm_write(input logic [159:0] img, output bit ok);
        send({1'b1, `SVC_WRITE_ASM, `ASM_CLASS, `INST_COMMAND, `ASM_ATTR, 16'h0000,
            `IMAGE_BYTES}, ok);
        if (ok) beats(img, 10, ok);
    endtask
endmodule

// File: test/test_host_io_image_access.sv
// bench for the host image access block
`include "host_io_params.svh"
module test_host_io_image_access;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, reset_n, hdr_ready, wr_ready, rsp_valid, rsp_done, rsp_error, cmd_update;
    logic hdr_valid, hdr_is_cip, wr_valid, upd, done, ok;
    logic [7:0] hdr_code, hdr_class, hdr_instance, hdr_attribute, rsp_code;
    logic [15:0] hdr_addr, hdr_qty, wr_data, rsp_data;
    logic [159:0] resp_image, cmd_image, img_a, e;
    logic [8:0] st;
    logic [15:0] got [$];
    int error_cnt = 0, n_checks = 0;
    localparam logic [15:0] len = `IMAGE_BYTES;
    host_model host (.clock(clock), .hdr_ready(hdr_ready), .wr_ready(wr_ready),
        .hdr_valid(hdr_valid), .hdr_is_cip(hdr_is_cip), .hdr_code(hdr_code),
        .hdr_class(hdr_class), .hdr_instance(hdr_instance), .hdr_attribute(hdr_attribute),
        .hdr_addr(hdr_addr), .hdr_qty(hdr_qty), .wr_valid(wr_valid), .wr_data(wr_data));
    host_io_image_access DUT (.clock(clock), .reset_n(reset_n), .hdr_valid(hdr_valid),
        .hdr_is_cip(hdr_is_cip), .hdr_code(hdr_code), .hdr_class(hdr_class),
        .hdr_instance(hdr_instance), .hdr_attribute(hdr_attribute), .hdr_addr(hdr_addr),
        .hdr_qty(hdr_qty), .hdr_ready(hdr_ready), .wr_valid(wr_valid), .wr_data(wr_data),
        .wr_ready(wr_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_done(rsp_done), .rsp_error(rsp_error), .rsp_code(rsp_code),
        .resp_image(resp_image), .cmd_image(cmd_image), .cmd_update(cmd_update));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [159:0] pat(input logic [15:0] b);
        for (int k = 0; k < 10; k++) pat[16*k +: 16] = b + 16'(k * 16'h0111);
    endfunction
    function automatic logic [64:0] mb(input logic [7:0] f, input logic [15:0] a, q);
        return {1'b0, f, 24'h000000, a, q};
    endfunction
    function automatic logic [64:0] cip(input logic [7:0] s, c, i, t, input logic [15:0] q);
        return {1'b1, s, c, i, t, 16'h0000, q};
    endfunction
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic hang();
        error_cnt++;
        $display("[ERR] %0t no answer", $time);
        test_done();
    endtask
    task automatic chk(input logic [159:0] seen, input logic [159:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    // collect items up to the end pulse; a lost handshake ends the run
    task automatic fin(input bit ok);
        got = {};
        upd = 1'b0;
        done = 1'b0;
        if (!ok) hang();
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge clock);
            if (rsp_valid === 1'b1) got.push_back(rsp_data);
            if (cmd_update === 1'b1) upd = 1'b1;
            st = {rsp_error, rsp_code};
            done = (rsp_done === 1'b1);
        end
        if (!done) hang();
    endtask
    task automatic bad(input logic [64:0] r, input logic [7:0] c);
        host.send(r, ok);
        fin(ok);
        chk({got.size(), st}, {1'b1, c});
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_asm();
        host.asm_write(img_a, ok);
        fin(ok);
        chk({upd, st}, 10'h200);
        chk(cmd_image, img_a);
        host.asm_read(ok);
        fin(ok);
        chk(160'(got.size()), 160'hA);
        for (int k = 0; k < 10; k++) chk(got[k], resp_image[16*k +: 16]);
    endtask
    task automatic t_inputs();
        host.send(mb(`FC_RD_INPUTS, 16'h0030, 16'h0010), ok);
        fin(ok);
        for (int k = 0; k < 16; k++) chk(got[k], {15'h0000, resp_image[48+k]});
        host.send(mb(`FC_RD_INREGS, 16'h0003, 16'h0001), ok);
        fin(ok);
        chk(got[0], resp_image[63:48]);
        host.send(mb(`FC_RD_INPUTS, 16'h0000, 16'h0001), ok);
        fin(ok);
        chk(got[0], {15'h0000, resp_image[0]});
    endtask
    task automatic t_coils();
        e = img_a;
        e[17] = 1'b1; // coil 16401 lands in word 1 bit 1
        host.send(mb(`FC_WR_COIL, 16'h4011, 16'h0001), ok);
        if (ok) host.beats({144'h0, `COIL_ON}, 1, ok);
        fin(ok);
        chk(cmd_image, e);
        host.send(mb(`FC_RD_HOLDING, 16'h0401, 16'h0001), ok);
        fin(ok);
        chk(got[0], e[31:16]);
        host.send(mb(`FC_RD_COILS, 16'h4000, 16'h0001), ok);
        fin(ok);
        chk(got[0], {15'h0000, e[0]});
        host.send(mb(`FC_WR_REG, 16'h0400, 16'h0001), ok);
        if (ok) host.beats({144'h0, 16'h5A5A}, 1, ok);
        fin(ok);
        chk(cmd_image[15:0], 16'h5A5A);
        host.send(mb(`FC_MASK_REG, 16'h0400, 16'h0001), ok);
        if (ok) host.beats({128'h0, 16'h0033, 16'hFF00}, 2, ok);
        fin(ok);
        chk(cmd_image[15:0], 16'h5A33);
    endtask
    initial begin
        reset_n = 1'b0;
        resp_image = pat(16'h3C00);
        img_a = pat(16'hA000);
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        chk(cmd_image, 160'h0);
        t_asm();
        t_inputs();
        t_coils();
        bad(cip(8'h0F, `ASM_CLASS, `INST_RESPONSE, `ASM_ATTR, 16'h0014), `CIP_BAD_SERVICE);
        bad(cip(`SVC_READ_ASM, 8'h05, `INST_RESPONSE, `ASM_ATTR, 16'h0014), `CIP_NO_OBJECT);
        bad(cip(`SVC_READ_ASM, `ASM_CLASS, `INST_RESPONSE, 8'h02, 16'h0014), `CIP_BAD_ATTR);
        bad(cip(`SVC_READ_ASM, `ASM_CLASS, `INST_COMMAND, `ASM_ATTR, len), `CIP_NO_OBJECT);
        bad(cip(`SVC_WRITE_ASM, `ASM_CLASS, `INST_RESPONSE, `ASM_ATTR, len), `CIP_NO_OBJECT);
        bad(cip(`SVC_WRITE_ASM, `ASM_CLASS, `INST_COMMAND, `ASM_ATTR, 16'h0013), `CIP_SHORT);
        bad(cip(`SVC_WRITE_ASM, `ASM_CLASS, `INST_COMMAND, `ASM_ATTR, 16'h0015), `CIP_LONG);
        bad(mb(8'h17, 16'h0000, 16'h0001), `EXC_FUNCTION);
        bad(mb(`FC_RD_INREGS, 16'h0009, 16'h0002), `EXC_ADDRESS);
        bad(mb(`FC_WR_REG, 16'h040A, 16'h0001), `EXC_ADDRESS);
        test_done();
    end
endmodule
